// >>> hw/fic_controller.sv
// design: five level vectored interrupt controller with an AXI4-Lite register slave
//
// Operation
// - thirteen sources, each vectoring to its own fixed address
// - maskable source eligible only with its own enable and the global gate set
// - global gate clear blocks every maskable source
// - power-fail gated only by its own enable, ignores the global gate
// - five levels, 4 highest, level 4 only for power-fail
// - other sources take level 3..0 from a high and a low priority bit
// - enabled power-fail always wins arbitration
// - ties on level go to the earliest natural order, power-fail first
// - ext0 order 1 vector 03h, flag control bit 1; timer0 vector 0bh
// - ext1 order 3 vector 13h flag bit 3; timer1 vector 1bh flag bit 7
// - serial0 requests on receive or transmit flag, vector 23h
// - timer2 requests on overflow or external flag, vector 2bh
// - serial1 requests on receive or transmit flag, vector 3bh
// - ext2 and ext3 vectors 43h, 4bh, flags bits 4,5, enables bits 0,1
// - ext4 and ext5 vectors 53h, 5bh, flags bits 6,7, enables bits 2,3
// - watchdog lowest order, vector 63h, priority bit 4, flag watchdog bit 3
// - request flags set on their condition whether enabled or not
// - timer0 and timer1 overflow flags cleared by hardware on vectoring
// - edge mode ext0/ext1 flag cleared on vectoring; level mode follows pin
module fic_controller (
	input  logic                          ref_clk,
	input  logic                          nrst,
	input  logic [fic_pkg::ADDR_W-1:0]    awaddr,
	input  logic                          awvalid,
	output logic                          awready,
	input  logic [31:0]                   wdata,
	input  logic [3:0]                    wstrb,
	input  logic                          wvalid,
	output logic                          wready,
	output logic [1:0]                    bresp,
	output logic                          bvalid,
	input  logic                          bready,
	input  logic [fic_pkg::ADDR_W-1:0]    araddr,
	input  logic                          arvalid,
	output logic                          arready,
	output logic [31:0]                   rdata,
	output logic [1:0]                    rresp,
	output logic                          rvalid,
	input  logic                          rready,
	input  fic_pkg::fic_events_type       events,
	output logic                          irq_req,
	output logic [7:0]                    irq_vector,
	output logic [2:0]                    irq_level,
	input  logic                          irq_ack,
	input  logic                          irq_return
);

	fic_pkg::fic_state_type               q;
	fic_pkg::fic_state_type               d;
	logic [fic_pkg::SRC_COUNT-1:0]        pend;
	logic [fic_pkg::SRC_COUNT-1:0]        en;
	logic [fic_pkg::SRC_COUNT-1:0][2:0]   lvl;
	logic                                 best_ok;
	logic [3:0]                           best;
	logic [2:0]                           best_lvl;
	logic [2:0]                           top;
	logic                                 top_ok;
	logic                                 aw_hit;
	logic                                 w_hit;
	logic                                 ack;
	logic [3:0]                           widx;

	// mapped when word aligned, the index names a register or status and upper bits are clear
	function automatic logic addr_ok(input logic [fic_pkg::ADDR_W-1:0] a);
		return (a[1:0] == 2'h0) && (a[fic_pkg::ADDR_W-1:6] == '0)
			&& (a[5:2] <= fic_pkg::IDX_STATUS);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// combinational next state

	always_comb begin
		d        = q;
		pend     = '0;
		en       = '0;
		lvl      = '0;
		best_ok  = 1'b0;
		best     = 4'h0;
		best_lvl = 3'h0;
		top      = 3'h0;
		top_ok   = 1'b0;
		aw_hit   = awvalid && q.awready;
		w_hit    = wvalid && q.wready;
		ack      = irq_ack && q.irq_req;
		widx     = 4'h0;

		// read channel: answer one cycle after the address is taken
		if (q.rvalid && rready) begin
			d.rvalid  = 1'b0;
			d.arready = 1'b1;
		end
		if (arvalid && q.arready) begin
			d.arready = 1'b0;
			d.rvalid  = 1'b1;
			d.rdata   = 32'h0;
			d.rresp   = fic_pkg::RESP_OKAY;
			if (!addr_ok(araddr)) begin
				d.rresp = fic_pkg::RESP_SLVERR;
			end else if (araddr[5:2] == fic_pkg::IDX_STATUS) begin
				d.rdata = {15'h0, q.irq_req, q.in_service, q.irq_level, q.irq_vector};
			end else begin
				d.rdata = {24'h0, q.regs[araddr[5:2]]};
			end
		end

		// write channel: address and data in either order
		if (aw_hit) begin
			d.aw_addr = awaddr;
		end
		if (w_hit) begin
			d.w_data = wdata[7:0];
			d.w_strb = wstrb[0];
		end
		case (q.wr)
			fic_pkg::WR_IDLE: begin
				if (aw_hit && w_hit) begin
					d.wr = fic_pkg::WR_RESP;
				end else if (aw_hit) begin
					d.wr = fic_pkg::WR_ADDR;
				end else if (w_hit) begin
					d.wr = fic_pkg::WR_DATA;
				end
			end
			fic_pkg::WR_ADDR: begin
				if (w_hit) begin
					d.wr = fic_pkg::WR_RESP;
				end
			end
			fic_pkg::WR_DATA: begin
				if (aw_hit) begin
					d.wr = fic_pkg::WR_RESP;
				end
			end
			fic_pkg::WR_RESP: begin
				if (bready) begin
					d.wr     = fic_pkg::WR_IDLE;
					d.bvalid = 1'b0;
				end
			end
			default: begin
				d.wr = fic_pkg::WR_IDLE;
			end
		endcase
		if (d.wr == fic_pkg::WR_RESP && q.wr != fic_pkg::WR_RESP) begin
			d.bvalid = 1'b1;
			d.bresp  = addr_ok(d.aw_addr) ? fic_pkg::RESP_OKAY : fic_pkg::RESP_SLVERR;
			widx     = d.aw_addr[5:2];
			// status is read only; a write to it is accepted and dropped
			if (addr_ok(d.aw_addr) && d.w_strb && widx != fic_pkg::IDX_STATUS) begin
				d.regs[widx] = d.w_data;
			end
		end
		d.awready = (d.wr == fic_pkg::WR_IDLE) || (d.wr == fic_pkg::WR_DATA);
		d.wready  = (d.wr == fic_pkg::WR_IDLE) || (d.wr == fic_pkg::WR_ADDR);

		////////////////////////////////////////////////////////////////////////
		// vectoring and return; clears go first so a same-cycle set wins

		if (ack) begin
			d.in_service[q.irq_level] = 1'b1;
			case (q.irq_src)
				fic_pkg::SRC_T0: begin
					d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_T0_OVF] = 1'b0;
				end
				fic_pkg::SRC_T1: begin
					d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_T1_OVF] = 1'b0;
				end
				fic_pkg::SRC_EXT0: begin
					if (q.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT0_EDGE]) begin
						d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT0_FLAG] = 1'b0;
					end
				end
				fic_pkg::SRC_EXT1: begin
					if (q.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT1_EDGE]) begin
						d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT1_FLAG] = 1'b0;
					end
				end
				default: begin
					// other flags stay for software to clear
				end
			endcase
		end
		// return retires the highest running level, uncovering the one beneath
		for (int i = 0; i < 5; i++) begin
			if (q.in_service[i]) begin
				top    = 3'(i);
				top_ok = 1'b1;
			end
		end
		if (irq_return && top_ok) begin
			d.in_service[top] = 1'b0;
		end

		////////////////////////////////////////////////////////////////////////
		// flag setting, whatever the enables hold

		if (d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT0_EDGE]) begin
			if (events.ext0_level && !q.ext_prev[0]) begin
				d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT0_FLAG] = 1'b1;
			end
		end else begin
			d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT0_FLAG] = events.ext0_level;
		end
		if (d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT1_EDGE]) begin
			if (events.ext1_level && !q.ext_prev[1]) begin
				d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT1_FLAG] = 1'b1;
			end
		end else begin
			d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT1_FLAG] = events.ext1_level;
		end
		d.ext_prev = {events.ext1_level, events.ext0_level};
		d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_T0_OVF] |= events.timer0_overflow;
		d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_T1_OVF] |= events.timer1_overflow;
		d.regs[fic_pkg::IDX_SERIAL0_CTRL][fic_pkg::BIT_RX] |= events.serial0_receive;
		d.regs[fic_pkg::IDX_SERIAL0_CTRL][fic_pkg::BIT_TX] |= events.serial0_transmit;
		d.regs[fic_pkg::IDX_TIMER2_CTRL][fic_pkg::BIT_T2_OVF] |= events.timer2_overflow;
		d.regs[fic_pkg::IDX_TIMER2_CTRL][fic_pkg::BIT_T2_EXT] |= events.timer2_external;
		d.regs[fic_pkg::IDX_SERIAL1_CTRL][fic_pkg::BIT_RX] |= events.serial1_receive;
		d.regs[fic_pkg::IDX_SERIAL1_CTRL][fic_pkg::BIT_TX] |= events.serial1_transmit;
		d.regs[fic_pkg::IDX_EXT_FLAG][fic_pkg::BIT_EXT2_FLAG +: 4] |= events.ext2_to_5;
		d.regs[fic_pkg::IDX_WATCHDOG_CTRL][fic_pkg::BIT_WD_FLAG] |= events.watchdog;
		d.regs[fic_pkg::IDX_WATCHDOG_CTRL][fic_pkg::BIT_PF_FLAG] |= events.power_fail;

		////////////////////////////////////////////////////////////////////////
		// per-source pending, enable and level, read from the updated flags

		pend[0] = d.regs[fic_pkg::IDX_WATCHDOG_CTRL][fic_pkg::BIT_PF_FLAG];
		pend[1] = d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT0_FLAG];
		pend[2] = d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_T0_OVF];
		pend[3] = d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_EXT1_FLAG];
		pend[4] = d.regs[fic_pkg::IDX_TIMER_CTRL][fic_pkg::BIT_T1_OVF];
		pend[5] = |d.regs[fic_pkg::IDX_SERIAL0_CTRL][fic_pkg::BIT_TX:fic_pkg::BIT_RX];
		pend[6] = |d.regs[fic_pkg::IDX_TIMER2_CTRL][fic_pkg::BIT_T2_OVF:fic_pkg::BIT_T2_EXT];
		pend[7] = |d.regs[fic_pkg::IDX_SERIAL1_CTRL][fic_pkg::BIT_TX:fic_pkg::BIT_RX];
		pend[11:8] = d.regs[fic_pkg::IDX_EXT_FLAG][fic_pkg::BIT_EXT2_FLAG +: 4];
		pend[12] = d.regs[fic_pkg::IDX_WATCHDOG_CTRL][fic_pkg::BIT_WD_FLAG];

		// power-fail never looks at the global gate
		en[0]  = d.regs[fic_pkg::IDX_WATCHDOG_CTRL][fic_pkg::BIT_PF_EN];
		lvl[0] = fic_pkg::PF_LEVEL;
		for (int k = 0; k < fic_pkg::PLAIN_SRCS; k++) begin
			en[k+1]  = d.regs[fic_pkg::IDX_ENABLE][k]
				&& d.regs[fic_pkg::IDX_ENABLE][fic_pkg::BIT_GLOBAL_GATE];
			lvl[k+1] = {1'b0, d.regs[fic_pkg::IDX_PRIO_HIGH][k],
				d.regs[fic_pkg::IDX_PRIO_LOW][k]};
		end
		for (int k = 0; k < fic_pkg::EXT_SRCS; k++) begin
			en[k+fic_pkg::FIRST_EXT_SRC]  = d.regs[fic_pkg::IDX_EXT_ENABLE][k]
				&& d.regs[fic_pkg::IDX_ENABLE][fic_pkg::BIT_GLOBAL_GATE];
			lvl[k+fic_pkg::FIRST_EXT_SRC] = {1'b0, d.regs[fic_pkg::IDX_EXT_PRIO_HIGH][k],
				d.regs[fic_pkg::IDX_EXT_PRIO_LOW][k]};
		end

		// scan from the last order down with >= so the earliest order keeps ties;
		// a candidate must sit strictly above every level in service
		for (int i = fic_pkg::SRC_COUNT - 1; i >= 0; i--) begin
			if (pend[i] && en[i] && ((d.in_service >> lvl[i]) == 5'h0)
					&& (!best_ok || lvl[i] >= best_lvl)) begin
				best_ok  = 1'b1;
				best     = 4'(i);
				best_lvl = lvl[i];
			end
		end
		d.irq_req    = best_ok;
		d.irq_src    = best;
		d.irq_level  = best_lvl;
		d.irq_vector = fic_pkg::VEC_TABLE[best];
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			q         <= '0;
			q.regs    <= {fic_pkg::REG_COUNT{fic_pkg::REG_RESET}};
			q.wr      <= fic_pkg::WR_IDLE;
			q.awready <= 1'b1;
			q.wready  <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign awready    = q.awready;
	assign wready     = q.wready;
	assign bvalid     = q.bvalid;
	assign bresp      = q.bresp;
	assign arready    = q.arready;
	assign rvalid     = q.rvalid;
	assign rdata      = q.rdata;
	assign rresp      = q.rresp;
	assign irq_req    = q.irq_req;
	assign irq_vector = q.irq_vector;
	assign irq_level  = q.irq_level;

endmodule // fic_controller

// >>> shared/fic_pkg.sv
// package: constants and carriers for the five level interrupt controller
package fic_pkg;

	localparam int ADDR_W    = 8;
	localparam int REG_COUNT = 12;
	localparam int SRC_COUNT = 13;

	// register indices; byte address is index times four
	localparam logic [3:0] IDX_ENABLE         = 4'h0;
	localparam logic [3:0] IDX_EXT_ENABLE     = 4'h1;
	localparam logic [3:0] IDX_EXT_FLAG       = 4'h2;
	localparam logic [3:0] IDX_TIMER_CTRL     = 4'h3;
	localparam logic [3:0] IDX_TIMER2_CTRL    = 4'h4;
	localparam logic [3:0] IDX_SERIAL0_CTRL   = 4'h5;
	localparam logic [3:0] IDX_SERIAL1_CTRL   = 4'h6;
	localparam logic [3:0] IDX_WATCHDOG_CTRL  = 4'h7;
	localparam logic [3:0] IDX_PRIO_LOW       = 4'h8;
	localparam logic [3:0] IDX_PRIO_HIGH      = 4'h9;
	localparam logic [3:0] IDX_EXT_PRIO_LOW   = 4'ha;
	localparam logic [3:0] IDX_EXT_PRIO_HIGH  = 4'hb;
	localparam logic [3:0] IDX_STATUS         = 4'hc;
	localparam logic [7:0] REG_RESET          = 8'h00;

	// field positions
	localparam int BIT_GLOBAL_GATE = 7;
	localparam int BIT_EXT0_EDGE   = 0;
	localparam int BIT_EXT0_FLAG   = 1;
	localparam int BIT_EXT1_EDGE   = 2;
	localparam int BIT_EXT1_FLAG   = 3;
	localparam int BIT_T0_OVF      = 5;
	localparam int BIT_T1_OVF      = 7;
	localparam int BIT_RX          = 0;
	localparam int BIT_TX          = 1;
	localparam int BIT_T2_EXT      = 6;
	localparam int BIT_T2_OVF      = 7;
	localparam int BIT_EXT2_FLAG   = 4;
	localparam int BIT_WD_FLAG     = 3;
	localparam int BIT_PF_FLAG     = 4;
	localparam int BIT_PF_EN       = 5;
	localparam int PLAIN_SRCS      = 7;
	localparam int EXT_SRCS        = 5;
	localparam int FIRST_EXT_SRC   = 8;

	// source numbers that hardware clears on vectoring
	localparam logic [3:0] SRC_EXT0 = 4'h1;
	localparam logic [3:0] SRC_T0   = 4'h2;
	localparam logic [3:0] SRC_EXT1 = 4'h3;
	localparam logic [3:0] SRC_T1   = 4'h4;

	localparam logic [2:0] PF_LEVEL = 3'h4;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// vectors by natural order, order 0 in the low byte
	localparam logic [SRC_COUNT-1:0][7:0] VEC_TABLE = {
		8'h63, 8'h5b, 8'h53, 8'h4b, 8'h43, 8'h3b, 8'h2b,
		8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03, 8'h33};

	typedef logic [REG_COUNT-1:0][7:0] fic_regs_type;

	// request conditions from the peripherals; ext levels, the rest one-cycle pulses
	typedef struct packed {
		logic       power_fail;
		logic       ext0_level;
		logic       ext1_level;
		logic       timer0_overflow;
		logic       timer1_overflow;
		logic       serial0_receive;
		logic       serial0_transmit;
		logic       timer2_overflow;
		logic       timer2_external;
		logic       serial1_receive;
		logic       serial1_transmit;
		logic [3:0] ext2_to_5;
		logic       watchdog;
	} fic_events_type;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_ADDR = 2'b01,
		WR_RESP = 2'b11,
		WR_DATA = 2'b10
	} fic_wr_state_type;

	typedef struct packed {
		fic_regs_type          regs;
		logic [1:0]            ext_prev;
		logic [4:0]            in_service;
		logic                  irq_req;
		logic [7:0]            irq_vector;
		logic [3:0]            irq_src;
		logic [2:0]            irq_level;
		fic_wr_state_type      wr;
		logic [ADDR_W-1:0]     aw_addr;
		logic [7:0]            w_data;
		logic                  w_strb;
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
	} fic_state_type;

endpackage

// >>> test/fic_controller_sva.sv
// checker: arbitration, nesting and bus handshake properties at the controller ports
module fic_controller_sva (
	input logic        ref_clk,
	input logic        nrst,
	input logic        awvalid,
	input logic        awready,
	input logic        wvalid,
	input logic        wready,
	input logic        bvalid,
	input logic        bready,
	input logic [1:0]  bresp,
	input logic        arvalid,
	input logic        arready,
	input logic        rvalid,
	input logic        rready,
	input logic [31:0] rdata,
	input logic        irq_req,
	input logic [7:0]  irq_vector,
	input logic [2:0]  irq_level,
	input logic        irq_ack,
	input logic        irq_return
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// in-service mirror built from the core handshake only, so it cannot share a design slip
	logic [4:0] svc_q;
	logic [4:0] svc_d;
	always_comb begin
		svc_d = svc_q;
		for (int i = 0; i < 5; i++) begin
			if (irq_return && svc_q[i] && (svc_q >> (i + 1)) == 5'h0) svc_d[i] = 1'b0;
		end
		if (irq_ack && irq_req) svc_d[irq_level] = 1'b1;
	end
	always_ff @(posedge ref_clk) begin
		if (!nrst) svc_q <= 5'h0;
		else svc_q <= svc_d;
	end
	//////////////////////////////////////////
	AST_VEC_SET:
		assert property (irq_req |-> irq_vector inside {8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
			8'h2b, 8'h33, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63}) else $error("stray vector");
	AST_PF_TOP:
		assert property (irq_req && irq_vector == 8'h33 |-> irq_level == 3'h4)
		else $error("power-fail not at level 4");
	AST_LVL_RANGE:
		assert property (irq_req && irq_vector != 8'h33 |-> irq_level <= 3'h3)
		else $error("maskable source above level 3");
	AST_NO_SAME_LVL:
		assert property (irq_req |-> (svc_q >> irq_level) == 5'h0)
		else $error("request not above the running level");
	AST_ACK_DROP:
		assert property (irq_ack && irq_req |=> !irq_req || irq_level > $past(irq_level))
		else $error("request kept after ack");
	AST_WR_RESP:
		assert property (awvalid && awready && wvalid && wready |=> bvalid && !awready)
		else $error("write not answered");
	AST_B_HOLD:
		assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	AST_RD_RESP:
		assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read not answered");
	AST_R_HOLD:
		assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
endmodule // fic_controller_sva

// >>> test/fic_core_model.sv
// partner: core side that acknowledges a vectored request after a chosen latency
module fic_core_model (
	input  logic       ref_clk,
	input  logic       nrst,
	input  logic       irq_req,
	input  logic       ack_en,
	input  logic [1:0] lat,
	output logic       irq_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_q;
	// one-cycle ack; the controller re-judges its request after it, so no double take
	always_ff @(posedge ref_clk) begin
		if (!nrst || !irq_req || irq_ack) begin
			wait_q  <= 2'h0;
			irq_ack <= 1'b0;
		end else if (wait_q != lat) begin
			wait_q <= wait_q + 2'h1;
		end else begin
			irq_ack <= ack_en;
		end
	end
endmodule // fic_core_model

// >>> test/fic_controller_tb_top.sv
// testbench: registers, flags, arbitration and nesting of the interrupt controller
module fic_controller_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [1:0] OK = fic_pkg::RESP_OKAY;
	localparam logic [1:0] ER = fic_pkg::RESP_SLVERR;
	logic                    ref_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic                    arvalid, arready, rvalid, rready, irq_req, irq_ack, irq_return;
	logic                    ack_en;
	logic [7:0]              awaddr, araddr, irq_vector, lfsr_q;
	logic [31:0]             wdata, rdata;
	logic [3:0]              wstrb;
	logic [2:0]              irq_level;
	logic [1:0]              bresp, rresp, lat;
	fic_pkg::fic_events_type events;
	logic [33:0]             exp_r[$];
	logic [1:0]              exp_b[$];
	logic [10:0]             exp_v[$];
	int                      err_total, checks;
	logic [7:0] vt[10] = '{8'h0b, 8'h1b, 8'h23, 8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
	logic [7:0] ca[10] = '{8'h0, 8'h0, 8'h14, 8'h10, 8'h18, 8'h8, 8'h8, 8'h8, 8'h8, 8'h1c};
	logic [7:0] cv[10] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'he0, 8'hc0, 8'h80, 8'h0, 8'h0};
	fic_controller u_fic_controller (.ref_clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .events, .irq_req, .irq_vector, .irq_level, .irq_ack, .irq_return);
	fic_core_model u_fic_core_model (.ref_clk, .nrst, .irq_req, .ack_en, .lat, .irq_ack);
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	//////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = OK);
		exp_b.push_back(r);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bready && bvalid) bready <= 1'b0;
		end while (awvalid || wvalid || bready);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = OK);
		exp_r.push_back({r, 24'h0, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rready && rvalid) rready <= 1'b0;
		end while (arvalid || rready);
	endtask
	// the ext pin levels survive a pulse; everything else is a one-cycle set
	task automatic pulse(input logic [15:0] e);
		events <= events | e;
		@(posedge ref_clk);
		events <= events & 16'h6000;
	endtask
	task automatic take(input logic [7:0] v, input logic [2:0] l);
		exp_v.push_back({v, l});
		ack_en <= 1'b1;
		for (int k = 0; k < 40 && !irq_ack; k++) @(posedge ref_clk);
		ack_en <= 1'b0;
	endtask
	task automatic ret;
		irq_return <= 1'b1;
		@(posedge ref_clk);
		irq_return <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic idle_chk;
		repeat (3) @(posedge ref_clk);
		cmp(34'(irq_req), 34'h0, "idle");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	//////////////////////////////////////////
	always @(posedge ref_clk) begin
		if (rvalid && rready) cmp({rresp, rdata}, exp_r.size() ? exp_r.pop_front() : 'x, "read");
		if (bvalid && bready) cmp(34'(bresp), exp_b.size() ? exp_b.pop_front() : 'x, "write");
		if (irq_ack && irq_req)
			cmp({irq_vector, irq_level}, exp_v.size() ? exp_v.pop_front() : 'x, "vector");
	end
	initial begin
		#600000;
		err_total++;
		tally_and_finish;
	end
	initial begin
		{nrst, awvalid, wvalid, bready, arvalid, rready, irq_return, ack_en} <= '0;
		{awaddr, araddr, wdata, lat, events} <= '0;
		wstrb <= 4'hf;
		lfsr_q = 8'h5f;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 12; i++) rd(8'(i * 4), 8'h00);
		rd(8'h34, 8'h00, ER);
		wr(8'h02, 8'h55, ER);
		for (int i = 8; i < 12; i++) begin
			lfsr_q = lfsr(lfsr_q);
			wr(8'(i * 4), lfsr_q);
			rd(8'(i * 4), lfsr_q);
			wr(8'(i * 4), 8'h00);
		end
		wr(8'h00, 8'h7f);
		wr(8'h04, 8'h1f);
		pulse(16'h1fff);
		idle_chk;
		rd(8'h0c, 8'ha0);
		rd(8'h10, 8'hc0);
		rd(8'h14, 8'h03);
		rd(8'h18, 8'h03);
		rd(8'h08, 8'hf0);
		rd(8'h1c, 8'h08);
		wr(8'h00, 8'hff);
		for (int i = 0; i < 10; i++) begin
			take(vt[i], 3'h0);
			if (i > 1) wr(ca[i], cv[i]);
			ret;
		end
		rd(8'h0c, 8'h00);
		wr(8'h28, 8'h10);
		wr(8'h2c, 8'h10);
		wr(8'h20, 8'h08);
		wr(8'h00, 8'h88);
		wr(8'h1c, 8'h20);
		lat <= 2'h2;
		pulse(16'h0801);
		take(8'h63, 3'h3);
		wr(8'h00, 8'h08);
		pulse(16'h8000);
		take(8'h33, 3'h4);
		wr(8'h1c, 8'h20);
		ret;
		ret;
		idle_chk;
		wr(8'h00, 8'h88);
		take(8'h1b, 3'h1);
		ret;
		lat <= 2'h0;
		wr(8'h0c, 8'h01);
		wr(8'h00, 8'h81);
		events.ext0_level <= 1'b1;
		take(8'h03, 3'h0);
		ret;
		idle_chk;
		wr(8'h00, 8'h01);
		wr(8'h0c, 8'h00);
		rd(8'h0c, 8'h02);
		events.ext0_level <= 1'b0;
		// the flag follows the pin one edge later, so let that edge pass before reading
		@(posedge ref_clk);
		rd(8'h0c, 8'h00);
		cmp(34'(exp_v.size() + exp_r.size() + exp_b.size()), 34'h0, "pending");
		tally_and_finish;
	end
endmodule // fic_controller_tb_top

bind fic_controller fic_controller_sva u_fic_controller_sva (.ref_clk, .nrst, .awvalid, .awready,
	.wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
	.irq_req, .irq_vector, .irq_level, .irq_ack, .irq_return);
